/* File: hdl/encoder_process_data_preset.sv */
// Encoder cyclic input words and preset handshake
// Contract
// RULE1: Four input words per cycle: flags, speed, revolutions, angle steps.
// RULE2: Flag bit 0 set while speed outside signed 16-bit; others zero.
// RULE3: Speed word is signed two's complement.
// RULE4: Forward: clockwise gives positive speed; backward gives negative.
// RULE5: Speed saturates at limits; normal output and flag clear on return.
// RULE6: Speed counts position increments per standard integration interval.
// RULE7: Revolution word holds whole revolutions in 15 bits.
// RULE8: Angle word holds steps in one turn, 8192 steps, 13 bits.
// RULE9: Position equals 8192 times revolutions plus angle steps.
// RULE10: Preset replaces output position with any value in range.
// RULE11: Host starts preset only during active cyclic exchange.
// RULE12: Host first writes preset revolution and angle words.
// RULE13: Unlock bit rising edge puts device in preset-ready state.
// RULE14: Request bit rising edge takes preset and sets acknowledge bit.
// RULE15: Check preconditions; load position, else reject and set error bit 15.
// RULE16: On completion set the parameter-done status bit.
// RULE17: Unlock falling edge clears parameter-done and acknowledge bits.
// RULE18: Host clears the request bit itself; device never clears it.
// RULE19: Host verifies reported position equals commanded preset.
// RULE20: Watchdog time defaults 125 ms, range 10 to 10000 ms.
// RULE21: Source and destination addresses default 1, range 1 to 65534.
// RULE22: Host preset value lies within 0 to 268435455.
// RULE23: Preset needs speed within idleness tolerance of 1 to 5 per interval.
// RULE24: Standard interval is multiplier times 5 ms base.
// RULE25: Edges found by comparing each new cyclic value with the previous.
// RULE26: Ack, error, done bits hold until unlock falls or new attempt; code clears the error bit only on a new attempt.
`timescale 1ns/1ps
`default_nettype none
module encoder_process_data_preset
	import encoder_pkg::*;
(
	input  wire logic               i_clk_sys,
	input  wire logic               i_resetn,
	input  wire logic               i_step_pulse,
	input  wire logic               i_step_cw,
	input  wire logic               i_cycle_strobe,
	input  wire logic               i_param_unlock_ctrl,
	input  wire logic [WORD_W-1:0]  i_host_control_word,
	input  wire logic [WORD_W-1:0]  i_preset_rev,
	input  wire logic [WORD_W-1:0]  i_preset_steps,
	input  wire logic               i_cfg_write,
	input  wire logic               i_cfg_dir_forward,
	input  wire logic [7:0]         i_cfg_std_mult,
	input  wire logic [3:0]         i_cfg_safe_mult,
	input  wire logic [2:0]         i_cfg_idle_tol,
	input  wire logic [13:0]        i_cfg_wd_ms,
	input  wire logic [15:0]        i_cfg_src_addr,
	input  wire logic [15:0]        i_cfg_dst_addr,
	input  wire logic               i_out_ready,
	output logic                    o_out_valid,
	output logic [WORD_W-1:0]       o_flag_word,
	output logic [WORD_W-1:0]       o_speed_word,
	output logic [WORD_W-1:0]       o_revolution_count,
	output logic [WORD_W-1:0]       o_angle_steps,
	output logic [WORD_W-1:0]       o_device_status_word,
	output logic                    o_param_done_status,
	output logic                    o_sample_dropped,
	output logic [13:0]             o_safety_watchdog_time,
	output logic [15:0]             o_src_addr,
	output logic [15:0]             o_dst_addr
);
	localparam int FW = 4 * WORD_W;

	function automatic logic [WIDE_W-1:0] mul_ms(input logic [7:0] m,
			input int base);
		mul_ms = WIDE_W'(m) * WIDE_W'(base);
	endfunction : mul_ms

	function automatic logic [WIDE_W-1:0] mag(input logic [WIDE_W-1:0] v);
		mag = v[WIDE_W-1] ? (~v + 1'b1) : v;
	endfunction : mag

	// Configuration registers
	logic                   dir_fwd_q;
	logic [7:0]             std_mult_q;
	logic [3:0]             safe_mult_q;
	logic [2:0]             idle_tol_q;
	logic [13:0]            wd_ms_q;
	logic [15:0]            src_q;
	logic [15:0]            dst_q;
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			dir_fwd_q   <= 1'b1;
			std_mult_q  <= STD_MULT_RST;
			safe_mult_q <= SAFE_MULT_RST;
			idle_tol_q  <= IDLE_TOL_RST;
			wd_ms_q     <= WD_MS_RST;
			src_q       <= ADDR_RST;
			dst_q       <= ADDR_RST;
		end else if (i_cfg_write) begin
			dir_fwd_q <= i_cfg_dir_forward;
			if (i_cfg_std_mult >= STD_MULT_MIN && i_cfg_std_mult <= STD_MULT_MAX) begin
				std_mult_q <= i_cfg_std_mult;
			end
			if (i_cfg_safe_mult >= SAFE_MULT_MIN
					&& i_cfg_safe_mult <= SAFE_MULT_MAX) begin
				safe_mult_q <= i_cfg_safe_mult;
			end
			if (i_cfg_idle_tol >= IDLE_TOL_MIN && i_cfg_idle_tol <= IDLE_TOL_MAX) begin
				idle_tol_q <= i_cfg_idle_tol;
			end
			if (i_cfg_wd_ms >= WD_MS_MIN && i_cfg_wd_ms <= WD_MS_MAX) begin
				wd_ms_q <= i_cfg_wd_ms; // [RULE20]
			end
			if (i_cfg_src_addr >= ADDR_MIN && i_cfg_src_addr <= ADDR_MAX) begin
				src_q <= i_cfg_src_addr; // [RULE21]
			end
			if (i_cfg_dst_addr >= ADDR_MIN && i_cfg_dst_addr <= ADDR_MAX) begin
				dst_q <= i_cfg_dst_addr; // [RULE21]
			end
		end
	end

	// Position counter
	logic [POS_W-1:0]       pos_q;
	logic                   load_pos;
	logic [POS_W-1:0]       load_val;
	logic                   step_up;
	assign step_up = (i_step_cw == dir_fwd_q); // [RULE4]
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			pos_q <= '0;
		end else if (load_pos) begin
			pos_q <= load_val; // [RULE10]
		end else if (i_step_pulse) begin
			pos_q <= step_up ? pos_q + 1'b1 : pos_q - 1'b1;
		end
	end

	// Standard interval speed measurement
	logic [WIDE_W-1:0]      std_tmr_q;
	logic [WIDE_W-1:0]      std_acc_q;
	logic [WIDE_W-1:0]      std_speed_q;
	logic signed [WIDE_W-1:0] step_delta;
	assign step_delta = !i_step_pulse ? '0 : (step_up ? 32'sd1 : -32'sd1);
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			std_tmr_q   <= '0;
			std_acc_q   <= '0;
			std_speed_q <= '0;
		end else if (std_tmr_q >= mul_ms(std_mult_q, STD_BASE_CYC) - 1) begin
			std_tmr_q   <= '0; // [RULE24]
			std_speed_q <= std_acc_q + step_delta; // [RULE6]
			std_acc_q   <= '0;
		end else begin
			std_tmr_q <= std_tmr_q + 1'b1;
			std_acc_q <= std_acc_q + step_delta;
		end
	end

	// Safety interval speed for the idleness check
	logic [WIDE_W-1:0]      safe_tmr_q;
	logic [WIDE_W-1:0]      safe_acc_q;
	logic [WIDE_W-1:0]      safe_speed_q;
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			safe_tmr_q   <= '0;
			safe_acc_q   <= '0;
			safe_speed_q <= '0;
		end else if (safe_tmr_q
				>= mul_ms({4'h0, safe_mult_q}, SAFE_BASE_CYC) - 1) begin
			safe_tmr_q   <= '0;
			safe_speed_q <= safe_acc_q + step_delta;
			safe_acc_q   <= '0;
		end else begin
			safe_tmr_q <= safe_tmr_q + 1'b1;
			safe_acc_q <= safe_acc_q + step_delta;
		end
	end

	// Saturation of the speed word
	logic                   ovf_pos;
	logic                   ovf_neg;
	logic [WORD_W-1:0]      speed_sat;
	assign ovf_pos = !std_speed_q[WIDE_W-1]
		&& (std_speed_q > {16'h0000, SPEED_POS_LIM});
	assign ovf_neg = std_speed_q[WIDE_W-1]
		&& (std_speed_q < {16'hffff, SPEED_NEG_LIM});
	always_comb begin
		if (ovf_pos) begin
			speed_sat = SPEED_POS_LIM; // [RULE5]
		end else if (ovf_neg) begin
			speed_sat = SPEED_NEG_LIM; // [RULE5]
		end else begin
			speed_sat = std_speed_q[WORD_W-1:0]; // [RULE3]
		end
	end

	// Cyclic frame into the FIFO
	logic [FW-1:0]          frame;
	logic [WORD_W-1:0]      flags;
	logic                   in_ready;
	logic                   fifo_valid;
	logic [FW-1:0]          fifo_data;
	always_comb begin
		flags = '0;
		flags[OVF_BIT] = ovf_pos || ovf_neg; // [RULE2]
	end
	assign frame = {flags, speed_sat, // [RULE1]
		{1'b0, pos_q[POS_W-1:STEP_W]}, // [RULE7] [RULE9]
		{3'b000, pos_q[STEP_W-1:0]}}; // [RULE8]
	word_fifo #(
		.WIDTH (FW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk_sys   (i_clk_sys),
		.i_resetn    (i_resetn),
		.i_in_data   (frame),
		.i_in_valid  (i_cycle_strobe),
		.o_in_ready  (in_ready),
		.o_out_data  (fifo_data),
		.o_out_valid (fifo_valid),
		.i_out_ready (i_out_ready)
	);
	logic out_take;
	assign out_take = fifo_valid && i_out_ready;
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_out_valid        <= 1'b0;
			o_flag_word        <= '0;
			o_speed_word       <= '0;
			o_revolution_count <= '0;
			o_angle_steps      <= '0;
			o_sample_dropped   <= 1'b0;
		end else begin
			o_out_valid      <= out_take;
			o_sample_dropped <= i_cycle_strobe && !in_ready;
			if (out_take) begin
				{o_flag_word, o_speed_word, o_revolution_count, o_angle_steps}
					<= fifo_data;
			end
		end
	end

	// Preset handshake
	preset_state_type       st_q;
	logic                   unlock_prev_q;
	logic                   req_prev_q;
	logic                   ack_q;
	logic                   err_q;
	logic                   done_q;
	logic [POS_W-1:0]       preset_q;
	logic                   unlock_rise;
	logic                   unlock_fall;
	logic                   req_rise;
	logic [WIDE_W-1:0]      preset_sum;
	logic                   preset_ok;
	logic                   range_ok;
	logic                   range_ok_q;
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			unlock_prev_q <= 1'b0;
			req_prev_q    <= 1'b0;
		end else if (i_cycle_strobe) begin
			unlock_prev_q <= i_param_unlock_ctrl; // [RULE25]
			req_prev_q    <= i_host_control_word[REQ_BIT]; // [RULE25]
		end
	end
	assign unlock_rise = i_cycle_strobe && i_param_unlock_ctrl && !unlock_prev_q;
	assign unlock_fall = i_cycle_strobe && !i_param_unlock_ctrl && unlock_prev_q;
	assign req_rise    = i_cycle_strobe && i_host_control_word[REQ_BIT]
		&& !req_prev_q;
	// Range is judged on the words taken with the request, not live inputs
	assign preset_sum  = (WIDE_W'(i_preset_rev) << STEP_W)
		+ WIDE_W'(i_preset_steps); // [RULE9]
	assign range_ok    = !i_preset_rev[WORD_W-1] && !i_preset_steps[WORD_W-1]
		&& (preset_sum <= WIDE_W'(POS_MAX));
	assign preset_ok   = (mag(safe_speed_q) <= WIDE_W'(idle_tol_q)) // [RULE23]
		&& range_ok_q;
	assign load_pos    = (st_q == PS_CHECK) && preset_ok;
	assign load_val    = preset_q;
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			st_q     <= PS_IDLE;
			ack_q    <= 1'b0;
			err_q    <= 1'b0;
			done_q   <= 1'b0;
			preset_q <= '0;
			range_ok_q <= 1'b0;
		end else begin
			case (st_q)
				PS_IDLE: begin
					if (unlock_rise) begin
						st_q <= PS_READY; // [RULE13]
					end
				end
				PS_READY: begin
					if (unlock_fall) begin
						st_q <= PS_IDLE;
					end else if (req_rise) begin
						preset_q <= preset_sum[POS_W-1:0]; // [RULE14]
						range_ok_q <= range_ok; // [RULE15]
						ack_q    <= 1'b1; // [RULE14]
						err_q    <= 1'b0; // [RULE26]
						done_q   <= 1'b0; // [RULE26]
						st_q     <= PS_CHECK;
					end
				end
				PS_CHECK: begin
					err_q  <= !preset_ok; // [RULE15]
					// An unlock fall on this strobe must not be lost
					if (unlock_fall) begin
						ack_q  <= 1'b0; // [RULE17]
						done_q <= 1'b0; // [RULE17]
						st_q   <= PS_IDLE;
					end else begin
						done_q <= 1'b1; // [RULE16]
						st_q   <= PS_DONE;
					end
				end
				PS_DONE: begin
					if (unlock_fall) begin
						ack_q  <= 1'b0; // [RULE17]
						done_q <= 1'b0; // [RULE17]
						st_q   <= PS_IDLE;
					end else if (req_rise) begin
						preset_q <= preset_sum[POS_W-1:0];
						range_ok_q <= range_ok; // [RULE15]
						ack_q    <= 1'b1;
						err_q    <= 1'b0; // [RULE26]
						done_q   <= 1'b0; // [RULE26]
						st_q     <= PS_CHECK;
					end
				end
				default: begin
					st_q <= PS_IDLE;
				end
			endcase
		end
	end
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_device_status_word   <= '0;
			o_param_done_status    <= 1'b0;
			o_safety_watchdog_time <= WD_MS_RST;
			o_src_addr             <= ADDR_RST;
			o_dst_addr             <= ADDR_RST;
		end else begin
			o_device_status_word          <= '0;
			o_device_status_word[ACK_BIT] <= ack_q;
			o_device_status_word[ERR_BIT] <= err_q;
			o_param_done_status           <= done_q;
			o_safety_watchdog_time        <= wd_ms_q;
			o_src_addr                    <= src_q;
			o_dst_addr                    <= dst_q;
		end
	end
endmodule : encoder_process_data_preset
`default_nettype wire

/* File: hdl/encoder_pkg.sv */
// Constants and types for the encoder process-data and preset block
package encoder_pkg;
	localparam int           WORD_W           = 16;
	localparam int           POS_W            = 28;
	localparam int           REV_W            = 15;
	localparam int           STEP_W           = 13;
	localparam int           WIDE_W           = 32;
	localparam int           CLK_HZ           = 40000000;
	localparam int           STD_BASE_MS      = 5;
	localparam int           STD_BASE_CYC     = (CLK_HZ / 1000) * STD_BASE_MS;
	localparam int           SAFE_BASE_MS     = 50;
	localparam int           SAFE_BASE_CYC    = (CLK_HZ / 1000) * SAFE_BASE_MS;
	localparam int           FIFO_DEPTH       = 4;
	localparam logic [7:0]   STD_MULT_RST     = 8'h14;
	localparam logic [7:0]   STD_MULT_MIN     = 8'h01;
	localparam logic [7:0]   STD_MULT_MAX     = 8'h64;
	localparam logic [3:0]   SAFE_MULT_RST    = 4'h2;
	localparam logic [3:0]   SAFE_MULT_MIN    = 4'h1;
	localparam logic [3:0]   SAFE_MULT_MAX    = 4'ha;
	localparam logic [2:0]   IDLE_TOL_RST     = 3'h1;
	localparam logic [2:0]   IDLE_TOL_MIN     = 3'h1;
	localparam logic [2:0]   IDLE_TOL_MAX     = 3'h5;
	localparam logic [13:0]  WD_MS_RST        = 14'h007d;
	localparam logic [13:0]  WD_MS_MIN        = 14'h000a;
	localparam logic [13:0]  WD_MS_MAX        = 14'h2710;
	localparam logic [15:0]  ADDR_RST         = 16'h0001;
	localparam logic [15:0]  ADDR_MIN         = 16'h0001;
	localparam logic [15:0]  ADDR_MAX         = 16'hfffe;
	localparam logic [27:0]  POS_MAX          = 28'hfffffff;
	localparam int           OVF_BIT          = 0;
	localparam int           ACK_BIT          = 0;
	localparam int           ERR_BIT          = 15;
	localparam int           REQ_BIT          = 0;
	localparam logic [15:0]  SPEED_POS_LIM    = 16'h7fff;
	localparam logic [15:0]  SPEED_NEG_LIM    = 16'h8000;
	typedef enum logic [1:0] {
		PS_IDLE,
		PS_READY,
		PS_CHECK,
		PS_DONE
	} preset_state_type;
endpackage : encoder_pkg

/* File: hdl/word_fifo.sv */
// Small FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 4
) (
	input  wire logic             i_clk_sys,
	input  wire logic             i_resetn,
	input  wire logic [WIDTH-1:0] i_in_data,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	output logic [WIDTH-1:0]      o_out_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;
	assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign o_out_valid = (cnt_q != '0);
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;
	assign o_out_data  = mem_q[rd_q];
	always_ff @(posedge i_clk_sys) begin
		if (push) begin
			mem_q[wr_q] <= i_in_data;
		end
	end
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : word_fifo
`default_nettype wire

/* File: verification/encoder_process_data_preset_checker.sv */
// Property checker for the encoder process-data and preset block
`timescale 1ns/1ps
`default_nettype none
module encoder_process_data_preset_checker
	import encoder_pkg::*;
(
	input wire logic              i_clk_sys,
	input wire logic              i_resetn,
	input wire logic              i_param_unlock_ctrl,
	input wire logic [WORD_W-1:0] i_host_control_word,
	input wire logic [WORD_W-1:0] o_flag_word,
	input wire logic [WORD_W-1:0] o_speed_word,
	input wire logic [WORD_W-1:0] o_revolution_count,
	input wire logic [WORD_W-1:0] o_angle_steps,
	input wire logic [WORD_W-1:0] o_device_status_word,
	input wire logic              o_param_done_status,
	input wire logic [13:0]       o_safety_watchdog_time,
	input wire logic [15:0]       o_src_addr,
	input wire logic [15:0]       o_dst_addr
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);
	AST_FLAG_RSVD: assert property (
		o_flag_word[15:1] == 15'h0000) else $error("flag reserved bits set");
	AST_SATURATE: assert property (
		o_flag_word[OVF_BIT] |->
		o_speed_word == SPEED_POS_LIM || o_speed_word == SPEED_NEG_LIM)
		else $error("speed not at a limit during overflow");
	AST_REV_WIDTH: assert property (
		o_revolution_count[15] == 1'b0) else $error("revolutions over 15 bits");
	AST_ANGLE_WIDTH: assert property (
		o_angle_steps[15:13] == 3'h0) else $error("angle over 13 bits");
	AST_STAT_RSVD: assert property (
		o_device_status_word[14:1] == 14'h0000)
		else $error("status reserved bits set");
	AST_ACK_CAUSE: assert property (
		$rose(o_device_status_word[ACK_BIT]) |->
		$past(i_host_control_word[REQ_BIT], 2) && $past(i_param_unlock_ctrl, 2))
		else $error("acknowledge without unlocked request");
	AST_DONE_ACK: assert property (
		$rose(o_param_done_status) |-> o_device_status_word[ACK_BIT])
		else $error("done without acknowledge");
	AST_DONE_FALL: assert property (
		$fell(o_param_done_status) |->
		!$past(i_param_unlock_ctrl) || $past(i_host_control_word[REQ_BIT]))
		else $error("done cleared while unlocked");
	AST_ACK_FALL: assert property (
		$fell(o_device_status_word[ACK_BIT]) |->
		!$past(i_param_unlock_ctrl) || $past(i_host_control_word[REQ_BIT]))
		else $error("acknowledge cleared while unlocked");
	AST_WD_RANGE: assert property (
		o_safety_watchdog_time >= WD_MS_MIN && o_safety_watchdog_time <= WD_MS_MAX)
		else $error("watchdog time out of range");
	AST_ADDR_RANGE: assert property (
		o_src_addr >= ADDR_MIN && o_src_addr <= ADDR_MAX &&
		o_dst_addr >= ADDR_MIN && o_dst_addr <= ADDR_MAX)
		else $error("address out of range");
endmodule : encoder_process_data_preset_checker
bind encoder_process_data_preset encoder_process_data_preset_checker
	i_checker (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
	.i_param_unlock_ctrl(i_param_unlock_ctrl),
	.i_host_control_word(i_host_control_word), .o_flag_word(o_flag_word),
	.o_speed_word(o_speed_word), .o_revolution_count(o_revolution_count),
	.o_angle_steps(o_angle_steps), .o_param_done_status(o_param_done_status),
	.o_device_status_word(o_device_status_word), .o_dst_addr(o_dst_addr),
	.o_safety_watchdog_time(o_safety_watchdog_time), .o_src_addr(o_src_addr));
`default_nettype wire

/* File: verification/host_model.sv */
// Host side model: cyclic exchange strobes and frame consumer
`timescale 1ns/1ps
`default_nettype none
module host_model #(
	parameter int PERIOD = 8
) (
	input  wire logic i_clk_sys,
	input  wire logic i_resetn,
	input  wire logic i_stall,
	input  wire logic i_out_valid,
	output logic      o_cycle_strobe = 1'b0,
	output logic      o_out_ready,
	output int        o_frames = 0
);
	int cnt = 0;
	// Strobes only run while the exchange is up, never before reset ends
	always @(negedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt <= 0;
			o_cycle_strobe <= 1'b0;
		end else begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			o_cycle_strobe <= (cnt == 0);
		end
	end
	assign o_out_ready = !i_stall;
	// Each valid delivers the four words together
	always @(posedge i_clk_sys) begin
		if (i_out_valid)
			o_frames <= o_frames + 1;
	end
endmodule : host_model
`default_nettype wire

/* File: verification/test_encoder_process_data_preset.sv */
// Self-checking testbench for the encoder process-data and preset block
`timescale 1ns/1ps
`default_nettype none
module test_encoder_process_data_preset
	import encoder_pkg::*;
();
	logic        clk = 1'b0, rstn = 1'b0, step = 1'b0, cw = 1'b1;
	logic        unl = 1'b0, cfgw = 1'b0, dir = 1'b1, stall = 1'b0;
	logic [15:0] ctl = 16'h0000, prev = 16'h0000, pste = 16'h0000;
	logic [13:0] wdi = WD_MS_RST;
	logic [15:0] srci = ADDR_RST, dsti = ADDR_RST;
	logic        strb, rdy, vld, done, drop;
	logic [15:0] flg, spd, rev, ang, st, src, dst;
	logic [13:0] wd;
	int          frames, miscompares = 0, samples_checked = 0;
	always #12.5 clk = ~clk;
	encoder_process_data_preset i_encoder_process_data_preset (
		.i_clk_sys(clk), .i_resetn(rstn), .i_step_pulse(step),
		.i_step_cw(cw), .i_cycle_strobe(strb), .i_param_unlock_ctrl(unl),
		.i_host_control_word(ctl), .i_preset_rev(prev),
		.i_preset_steps(pste), .i_cfg_write(cfgw), .i_cfg_dir_forward(dir),
		.i_cfg_std_mult(STD_MULT_RST), .i_cfg_safe_mult(SAFE_MULT_RST),
		.i_cfg_idle_tol(IDLE_TOL_RST), .i_cfg_wd_ms(wdi),
		.i_cfg_src_addr(srci), .i_cfg_dst_addr(dsti), .i_out_ready(rdy),
		.o_out_valid(vld), .o_flag_word(flg), .o_speed_word(spd),
		.o_revolution_count(rev), .o_angle_steps(ang),
		.o_device_status_word(st), .o_param_done_status(done),
		.o_sample_dropped(drop), .o_safety_watchdog_time(wd),
		.o_src_addr(src), .o_dst_addr(dst));
	host_model i_host_model (.i_clk_sys(clk), .i_resetn(rstn),
		.i_stall(stall), .i_out_valid(vld), .o_cycle_strobe(strb),
		.o_out_ready(rdy), .o_frames(frames));
	task automatic end_of_test;
		if (miscompares == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test
	task automatic cmp(input logic [15:0] got, exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : cmp
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	// Waits for two fresh frames so the words reflect the present state
	task automatic sync;
		int f;
		f = frames;
		for (int i = 0; i < 300 && frames < f + 2; i++)
			@(negedge clk);
		if (frames < f + 2) begin
			miscompares++;
			$display("mismatch at %0t: no fresh frames", $time);
			end_of_test();
		end
	endtask : sync
	task automatic chkpos(input logic [15:0] r, a);
		sync();
		cmp(rev, r, "revolutions");
		cmp(ang, a, "angle");
		cmp(flg, 16'h0000, "flags");
	endtask : chkpos
	task automatic steps(input int n, input logic c);
		cw = c;
		step = 1'b1;
		cyc(n);
		step = 1'b0;
	endtask : steps
	task automatic cfg(input logic d, input logic [13:0] w,
			input logic [15:0] s, t);
		dir = d;
		wdi = w;
		srci = s;
		dsti = t;
		cfgw = 1'b1;
		cyc(1);
		cfgw = 1'b0;
		cyc(2);
	endtask : cfg
	task automatic preset(input logic [15:0] r, s, input logic e);
		prev = r;
		pste = s;
		cyc(20);
		unl = 1'b1;
		cyc(20);
		ctl = 16'h0001;
		cyc(20);
		cmp(st, {e, 14'h0000, 1'b1}, "status");
		cmp({15'h0000, done}, 16'h0001, "done set");
		unl = 1'b0;
		cyc(20);
		cmp(st, {e, 15'h0000}, "status cleared");
		cmp({15'h0000, done}, 16'h0000, "done cleared");
		ctl = 16'h0000;
		cyc(20);
	endtask : preset
	task automatic t_reset;
		cmp({2'b00, wd}, 16'h007d, "watchdog default");
		cmp(src, 16'h0001, "source default");
		cmp(dst, 16'h0001, "destination default");
		cmp(st, 16'h0000, "status reset");
		chkpos(16'h0000, 16'h0000);
		cmp(spd, 16'h0000, "speed at rest");
	endtask : t_reset
	task automatic t_config;
		cfg(1'b1, 14'h2710, 16'hfffe, 16'h000a);
		cmp({2'b00, wd}, 16'h2710, "watchdog max");
		cmp(src, 16'hfffe, "source max");
		cmp(dst, 16'h000a, "destination");
		cfg(1'b1, 14'h0009, 16'h0000, 16'hffff);
		cmp({2'b00, wd}, 16'h2710, "watchdog kept");
		cmp(src, 16'hfffe, "source kept");
		cmp(dst, 16'h000a, "destination kept");
	endtask : t_config
	task automatic t_count;
		steps(8195, 1'b1);
		chkpos(16'h0001, 16'h0003);
		cfg(1'b0, 14'h000a, 16'h0001, 16'h0001);
		steps(4, 1'b1);
		chkpos(16'h0000, 16'h1fff);
		cfg(1'b1, 14'h000a, 16'h0001, 16'h0001);
	endtask : t_count
	task automatic t_preset_ok;
		preset(16'h0003, 16'h0100, 1'b0);
		chkpos(16'h0003, 16'h0100);
	endtask : t_preset_ok
	task automatic t_preset_bad;
		preset(16'h8000, 16'h0000, 1'b1);
		chkpos(16'h0003, 16'h0100);
	endtask : t_preset_bad
	task automatic t_preset_max;
		preset(16'h7fff, 16'h1fff, 1'b0);
		chkpos(16'h7fff, 16'h1fff);
	endtask : t_preset_max
	task automatic t_no_unlock;
		ctl = 16'h0001;
		cyc(40);
		cmp(st, 16'h0000, "request while locked");
		ctl = 16'h0000;
		cyc(20);
	endtask : t_no_unlock
	task automatic t_fifo;
		logic seen;
		seen = 1'b0;
		stall = 1'b1;
		for (int i = 0; i < 80; i++) begin
			@(negedge clk);
			seen = seen | drop;
		end
		cmp({15'h0000, seen}, 16'h0001, "sample dropped when full");
		stall = 1'b0;
		chkpos(16'h7fff, 16'h1fff);
	endtask : t_fifo
	initial begin
		cyc(6);
		rstn = 1'b1;
		cyc(2);
		t_reset();
		t_config();
		t_count();
		t_preset_ok();
		t_preset_bad();
		t_preset_max();
		t_no_unlock();
		t_fifo();
		end_of_test();
	end
endmodule : test_encoder_process_data_preset
`default_nettype wire
